// File: common/sarsq_pkg.sv
// constants and types shared by the conversion sequencer
`default_nettype none

package sarsq_pkg;

    // ****************************************************************
    // clock rates and documented times
    // ****************************************************************
    localparam int SYS_CLK_NS = 10;
    localparam int CONV_CLK_NS = 12;
    localparam int CONV_MAX_NS = 14000;
    localparam int DATA_SETUP_NS = 20;
    localparam int SER_VALID_NS = 120;

    // ****************************************************************
    // conversion geometry
    // ****************************************************************
    localparam int N_BITS = 16;
    localparam logic [4:0] N_CLK_CYCLES = 5'h11;
    localparam logic [4:0] LAST_DECISION = 5'h10;
    localparam logic [15:0] SAR_INIT = 16'h0000;
    localparam logic [15:0] MSB_TRIAL = 16'h8000;

    // ****************************************************************
    // derived cycle counts
    // ****************************************************************
    // half period of the gated clock: one low half before t0 plus
    // sixteen full periods must fit the longest conversion time
    localparam int HALF_CYC = CONV_MAX_NS / ((2 * N_BITS + 1) * CONV_CLK_NS);
    localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CONV_CLK_NS;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CONV_CLK_NS - 1) / CONV_CLK_NS;
    localparam int SER_VALID_CYC = (SER_VALID_NS + CONV_CLK_NS - 1) / CONV_CLK_NS;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH
    } sarsq_state_t;

endpackage

`default_nettype wire

// File: core/sarsq_evt_sync.sv
// one-cycle event crossing from one clock domain into another
`timescale 1ns/1ns
`default_nettype none

module sarsq_evt_sync (
    input wire logic clk_src,
    input wire logic clk_dst,
    input wire logic nrst,
    input wire logic src_pulse,
    output logic dst_pulse
);

    logic src_tgl;
    logic meta;
    logic sync;
    logic sync_d;

    // the event becomes a level change so no edge of it can be missed
    always_ff @(posedge clk_src or negedge nrst) begin
        if (!nrst) begin
            src_tgl <= 1'b0;
        end else if (src_pulse) begin
            src_tgl <= ~src_tgl;
        end
    end

    // two flops, then the edge detector looks only at the second
    always_ff @(posedge clk_dst or negedge nrst) begin
        if (!nrst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta <= src_tgl;
            sync <= meta;
            sync_d <= sync;
        end
    end

    assign dst_pulse = sync ^ sync_d;

endmodule

`default_nettype wire

// File: core/sarsq_core.sv
// successive-approximation conversion sequencer with parallel and serial result
//
// Notes on behaviour
// - each conversion resolves 16 bits against the feedback code, MSB first
// - at each decision edge the trial bit takes the comparator level
// - a conversion request raises the busy flag
// - busy releases the gated clock, which then runs exactly 17 cycles
// - approximation bits and inhibit initialise on request trailing edge; busy rises on the leading edge
// - t0 sets MSB trial only; later edges decide one bit, try the next
// - the sequence ends with the LSB decision at the sixteenth decision edge
// - after the last decision busy falls, marking the parallel word valid
// - clearing busy stops the clock low until the next conversion
// - each parallel bit becomes valid on its own decision edge
// - parallel and serial outputs are negative true
// - parallel coding is complementary straight or offset binary per scaling
// - parallel data is valid at least 20 ns before busy falls
// - serial output sends MSB first, LSB last, non-return-to-zero
// - serial coding matches the parallel coding
// - serial and parallel outputs change only on rising output clock edges; pdata_n also goes to all ones at conversion start
// - serial data is valid 120 ns after a rising edge, sampled on falls
// - conversion completes within 14 us; host leaves 6 us acquisition
// - gated clock runs near 1.2 MHz nominal
`timescale 1ns/1ns
`default_nettype none

module sarsq_core
    import sarsq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_conv,
    input wire logic convert_start,
    input wire logic comp_in,
    output logic busy,
    output logic conv_clk_out,
    output logic serial_n,
    output logic [15:0] pdata_n,
    output logic [15:0] dac_code
);

    // ****************************************************************
    // functions
    // ****************************************************************
    // approximation register after the rising edge numbered k
    function automatic logic [15:0] sarsq_next(input logic [15:0] s,
                                               input logic [4:0] k,
                                               input logic c);
        logic [15:0] r;
        int idx;
        r = s;
        idx = N_BITS - int'(k);
        if (k == 5'h00) begin
            r = MSB_TRIAL;
        end else begin
            r[idx] = c;
            if (k < LAST_DECISION) begin
                r[idx - 1] = 1'b1;
            end
        end
        return r;
    endfunction

    // ****************************************************************
    // system clock side: request capture and busy flag
    // ****************************************************************
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic armed;
    logic trig_rise;
    logic trig_fall;
    logic start_sys;
    logic done_sys;
    logic start_conv;
    logic done_conv;

    assign trig_rise = trig_sync & ~trig_prev;
    assign trig_fall = trig_prev & ~trig_sync;
    assign start_sys = trig_fall & armed;

    // the request pin is asynchronous; only trig_sync is looked at
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= convert_start;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    // busy rises on the leading edge; a pulse seen while busy is dropped
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else if (trig_rise && !busy) begin
            busy <= 1'b1;
        end else if (done_sys) begin
            busy <= 1'b0;
        end
    end

    // the conversion itself starts on the trailing edge of an accepted pulse
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (trig_rise && !busy) begin
            armed <= 1'b1;
        end else if (trig_fall) begin
            armed <= 1'b0;
        end
    end

    // ****************************************************************
    // domain crossings
    // ****************************************************************
    sarsq_evt_sync u_start (
        .clk_src(clk_sys),
        .clk_dst(clk_conv),
        .nrst(nrst),
        .src_pulse(start_sys),
        .dst_pulse(start_conv)
    );

    sarsq_evt_sync u_done (
        .clk_src(clk_conv),
        .clk_dst(clk_sys),
        .nrst(nrst),
        .src_pulse(done_conv),
        .dst_pulse(done_sys)
    );

    // ****************************************************************
    // conversion clock side: sequencer
    // ****************************************************************
    sarsq_state_t state;
    logic [7:0] div_cnt;
    logic [4:0] step;
    logic [15:0] sar;
    logic comp_meta;
    logic comp_sync;
    logic tick;
    logic rise_evt;
    logic fall_evt;
    logic [15:0] next_sar;

    assign tick = (div_cnt == DIV_LAST);
    assign rise_evt = (state == ST_LOW) && tick;
    assign fall_evt = (state == ST_HIGH) && tick;
    assign done_conv = fall_evt && (step == N_CLK_CYCLES);
    assign next_sar = sarsq_next(sar, step, comp_sync);
    assign dac_code = sar;

    // comparator level is analog-timed; two flops, far shorter than a half period
    always_ff @(posedge clk_conv or negedge nrst) begin
        if (!nrst) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= comp_in;
            comp_sync <= comp_meta;
        end
    end

    // half-period divider; held at zero while the clock is inhibited
    always_ff @(posedge clk_conv or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 8'h00;
        end else if (state == ST_IDLE || tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // state and count of rising edges given in this conversion
    always_ff @(posedge clk_conv or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            step <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_conv) begin
                        state <= ST_LOW;
                        step <= 5'h00;
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        state <= ST_HIGH;
                        step <= step + 5'h01;
                    end
                end
                ST_HIGH: begin
                    if (tick) begin
                        // seventeenth fall ends the run and re-inhibits
                        state <= (step == N_CLK_CYCLES) ? ST_IDLE : ST_LOW;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // approximation register loads SAR_INIT at conversion start, otherwise moves only on rising edges of the gated clock
    always_ff @(posedge clk_conv or negedge nrst) begin
        if (!nrst) begin
            sar <= SAR_INIT;
        end else if (state == ST_IDLE && start_conv) begin
            sar <= SAR_INIT;
        end else if (rise_evt) begin
            sar <= next_sar;
        end
    end

    // gated clock output; low whenever inhibited
    always_ff @(posedge clk_conv or negedge nrst) begin
        if (!nrst) begin
            conv_clk_out <= 1'b0;
        end else if (rise_evt) begin
            conv_clk_out <= 1'b1;
        end else if (fall_evt || state == ST_IDLE) begin
            conv_clk_out <= 1'b0;
        end
    end

    // result pins are inverted copies; coding follows the analog scaling
    always_ff @(posedge clk_conv or negedge nrst) begin
        if (!nrst) begin
            pdata_n <= ~SAR_INIT;
            serial_n <= 1'b1;
        end else if (state == ST_IDLE && start_conv) begin
            pdata_n <= ~SAR_INIT;
        end else if (rise_evt) begin
            pdata_n <= ~next_sar;
            // t0 carries no decision: the host's first fall takes a dummy
            serial_n <= (step == 5'h00) ? 1'b1 : ~comp_sync;
        end
    end

    // ****************************************************************
    // checking helpers
    // ****************************************************************
    logic [4:0] fall_cnt;
    logic [10:0] conv_cnt;
    logic [7:0] since_rise;

    // counts gated falls, conversion length and time since last change
    always_ff @(posedge clk_conv or negedge nrst) begin
        if (!nrst) begin
            fall_cnt <= 5'h00;
            conv_cnt <= 11'h000;
            since_rise <= 8'h00;
        end else begin
            if (start_conv && state == ST_IDLE) begin
                fall_cnt <= 5'h00;
                conv_cnt <= 11'h000;
            end else begin
                fall_cnt <= fall_cnt + 5'(fall_evt);
                conv_cnt <= (state == ST_IDLE) ? conv_cnt : conv_cnt + 11'h001;
            end
            since_rise <= rise_evt ? 8'h00 : since_rise + 8'(since_rise != 8'hff);
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_busy_rise;
        @(posedge clk_sys) disable iff (!nrst)
        (trig_rise && !busy) |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

    property p_ignore_busy;
        @(posedge clk_sys) disable iff (!nrst)
        (trig_rise && busy && !armed && !done_sys) |=> !armed;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("retrigger accepted");

    property p_no_restart;
        @(posedge clk_conv) disable iff (!nrst) start_conv |-> state == ST_IDLE;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("start while running");

    property p_busy_fall;
        @(posedge clk_sys) disable iff (!nrst)
        $fell(busy) |-> $past(done_sys);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell early");

    property p_init;
        @(posedge clk_conv) disable iff (!nrst)
        (state == ST_IDLE && start_conv) |=> (sar == SAR_INIT && !conv_clk_out && step == 5'h00);
    endproperty
    a_init: assert property (p_init) else $error("bad initialisation");

    property p_first_trial;
        @(posedge clk_conv) disable iff (!nrst)
        (rise_evt && step == 5'h00) |=> (sar == MSB_TRIAL && conv_clk_out);
    endproperty
    a_first_trial: assert property (p_first_trial) else $error("bad t0 trial");

    property p_msb_keep;
        @(posedge clk_conv) disable iff (!nrst)
        (rise_evt && step == 5'h01) |=> (sar[15] == $past(comp_sync) && sar[14]);
    endproperty
    a_msb_keep: assert property (p_msb_keep) else $error("msb decision wrong");

    property p_serial;
        @(posedge clk_conv) disable iff (!nrst)
        (rise_evt && step != 5'h00) |=> serial_n == !$past(comp_sync);
    endproperty
    a_serial: assert property (p_serial) else $error("serial bit wrong");

    property p_parallel;
        @(posedge clk_conv) disable iff (!nrst)
        rise_evt |=> pdata_n == ~dac_code;
    endproperty
    a_parallel: assert property (p_parallel) else $error("parallel not inverted");

    property p_edges_only;
        @(posedge clk_conv) disable iff (!nrst)
        ($changed(pdata_n) || $changed(serial_n)) |-> ($past(rise_evt) || $past(start_conv));
    endproperty
    a_edges_only: assert property (p_edges_only) else $error("output moved off edge");

    property p_seventeen;
        @(posedge clk_conv) disable iff (!nrst)
        done_conv |-> (fall_cnt == 5'h10 && step == N_CLK_CYCLES);
    endproperty
    a_seventeen: assert property (p_seventeen) else $error("clock count not 17");

    property p_setup;
        @(posedge clk_conv) disable iff (!nrst)
        done_conv |-> since_rise >= 8'(DATA_SETUP_CYC);
    endproperty
    a_setup: assert property (p_setup) else $error("data late before busy");

    property p_conv_time;
        @(posedge clk_conv) disable iff (!nrst)
        (rise_evt && step == LAST_DECISION) |-> conv_cnt < 11'(CONV_MAX_CYC);
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion too long");

    property p_idle_low;
        @(posedge clk_conv) disable iff (!nrst)
        (state == ST_IDLE) |=> !conv_clk_out || $past(rise_evt);
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("clock runs when idle");

    c_done: cover property (@(posedge clk_conv) disable iff (!nrst) done_conv);
    c_all_kept: cover property (@(posedge clk_conv) disable iff (!nrst)
        done_conv && sar == 16'hffff);
    c_retrigger: cover property (@(posedge clk_sys) disable iff (!nrst) trig_rise && busy);

endmodule

`default_nettype wire

// File: verification/sarsq_host_model.sv
// host model: captures the parallel and serial result of each conversion
`timescale 1ns/1ns
`default_nettype none

module sarsq_host_model (
    input wire logic nrst,
    input wire logic busy,
    input wire logic conv_clk_out,
    input wire logic serial_n,
    input wire logic [15:0] pdata_n,
    output logic [15:0] par_word,
    output logic [15:0] ser_word,
    output logic [15:0] first_word,
    output int n_rise,
    output int n_fall,
    output int n_bad,
    output realtime setup_ns,
    output realtime period_ns,
    output realtime last_rise
);
    realtime t_chg;

    // counters restart with every accepted request
    always @(posedge busy) begin
        n_rise = 0;
        n_fall = 0;
        n_bad = 0;
    end

    // receiving register shifts on falls; the first bit in is a dummy
    always @(negedge conv_clk_out) begin
        ser_word = {ser_word[14:0], serial_n};
        n_fall++;
    end

    // clock period and the word shown at the first rise
    always @(posedge conv_clk_out) begin
        if (n_rise > 0) begin
            period_ns = $realtime - last_rise;
        end
        last_rise = $realtime;
        n_rise++;
        #1;
        if (n_rise == 1) begin
            first_word = pdata_n;
        end
    end

    // a data move while the clock is low means it did not follow a rise
    always @(pdata_n or serial_n) begin
        t_chg = $realtime;
        #1; // the clock moves in the same step; look once it has settled
        if (nrst === 1'b1 && n_rise > 0 && conv_clk_out !== 1'b1) begin
            n_bad++;
        end
    end

    // parallel word taken on the falling edge of busy
    always @(negedge busy) begin
        if (nrst === 1'b1) begin
            par_word = pdata_n;
            setup_ns = $realtime - t_chg;
        end
    end
endmodule

`default_nettype wire

// File: verification/sarsq_core_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none

module sarsq_core_tb
    import sarsq_pkg::*;
;
    logic clk_sys = 1'b0;
    logic clk_conv;
    logic nrst, convert_start, comp_in, busy, conv_clk_out, serial_n;
    logic [15:0] pdata_n, dac_code, vin, lfsr, par_word, ser_word, first_word;
    int err_count = 0;
    int n_tests = 0;
    int n_rise, n_fall, n_bad;
    realtime setup_ns, period_ns, last_rise;
    logic [15:0] corner [5] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h677a};

    sarsq_core uut (.clk_sys(clk_sys), .nrst(nrst), .clk_conv(clk_conv),
        .convert_start(convert_start), .comp_in(comp_in), .busy(busy),
        .conv_clk_out(conv_clk_out), .serial_n(serial_n), .pdata_n(pdata_n),
        .dac_code(dac_code));

    sarsq_host_model host (.nrst(nrst), .busy(busy), .conv_clk_out(conv_clk_out),
        .serial_n(serial_n), .pdata_n(pdata_n), .par_word(par_word),
        .ser_word(ser_word), .first_word(first_word), .n_rise(n_rise),
        .n_fall(n_fall), .n_bad(n_bad), .setup_ns(setup_ns),
        .period_ns(period_ns), .last_rise(last_rise));

    // ********************
    // clocks and comparator
    // ********************
    // system clock
    always #5 clk_sys = ~clk_sys;

    // conversion clock, offset so its edges never meet the bench drive times
    initial begin
        clk_conv = 1'b0;
        #3;
        forever #6 clk_conv = ~clk_conv;
    end

    // comparator: keep while the input is at or above the feedback code
    always @(posedge clk_conv) comp_in <= #1 (vin >= dac_code);

    // ********************
    // model and checks
    // ********************
    // successive approximation in integers, msb first
    function automatic logic [15:0] sar_model(input int v);
        int res = 0;
        for (int b = N_BITS - 1; b >= 0; b--) begin
            if (v >= (res | (1 << b))) begin
                res = res | (1 << b);
            end
        end
        return 16'(res);
    endfunction

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        n_tests++;
        if (got != exp) begin
            err_count++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic check_idle();
        chk_bit("idle_busy", 1'b0, busy);
        chk_bit("idle_clk", 1'b0, conv_clk_out);
        chk_bit("idle_ser", 1'b1, serial_n);
        chk_word("idle_pdata", 16'hffff, pdata_n);
    endtask

    // one conversion; extra sends a second request while busy
    task automatic convert(input logic [15:0] v, input int hold, input bit extra);
        logic [15:0] exp_n;
        realtime t_trail;
        int k;
        @(posedge clk_sys);
        #1 vin = v;
        exp_n = ~sar_model(int'(v));
        convert_start = 1'b1;
        repeat (hold) @(posedge clk_sys);
        #1 chk_bit("busy_on", 1'b1, busy);
        convert_start = 1'b0;
        t_trail = $realtime;
        if (extra) begin
            repeat (300) @(posedge clk_sys);
            #1 convert_start = 1'b1;
            repeat (5) @(posedge clk_sys);
            #1 convert_start = 1'b0;
        end
        k = 0;
        while (busy !== 1'b0 && k < 1600) begin
            @(posedge clk_sys);
            #1 k++;
        end
        chk_bit("busy_off", 1'b0, busy);
        chk_word("first", 16'h7fff, first_word);
        chk_word("pdata", exp_n, pdata_n);
        chk_word("host_par", exp_n, par_word);
        chk_word("host_ser", exp_n, ser_word);
        chk_word("dac", ~exp_n, dac_code);
        chk_cnt("rises", int'(N_CLK_CYCLES), n_rise);
        chk_cnt("falls", int'(N_CLK_CYCLES), n_fall);
        chk_cnt("period", 2 * HALF_CYC * CONV_CLK_NS, int'(period_ns));
        chk_cnt("setup_ok", 1, int'(setup_ns >= DATA_SETUP_NS));
        chk_cnt("time_ok", 1, int'(last_rise - t_trail <= CONV_MAX_NS));
        chk_cnt("bad_edges", 0, n_bad);
        repeat (600) @(posedge clk_sys);
        #1 chk_bit("clk_low", 1'b0, conv_clk_out);
        chk_bit("busy_idle", 1'b0, busy);
        chk_word("pdata_hold", exp_n, pdata_n);
        $display("test conversion %h done", v);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        nrst = 1'b0;
        convert_start = 1'b0;
        vin = 16'h0000;
        lfsr = 16'h0046;
        repeat (8) @(posedge clk_sys);
        #1 nrst = 1'b1;
        check_idle();
        repeat (3) @(posedge clk_sys);
        foreach (corner[i]) convert(corner[i], 5 + i, 1'b0);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            convert(lfsr, 5, i == 1);
        end
        // abort a conversion by reset part way through
        @(posedge clk_sys);
        #1 convert_start = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1 convert_start = 1'b0;
        repeat (500) @(posedge clk_sys);
        #1 nrst = 1'b0;
        #1 check_idle();
        repeat (3) @(posedge clk_sys);
        #1 nrst = 1'b1;
        check_idle();
        repeat (3) @(posedge clk_sys);
        convert(lfsr_next(lfsr), 6, 1'b0);
        $display("test reset abort done");
        finish_test();
    end

    // watchdog sized for about fifteen conversions with acquisition
    initial begin
        #(15 * (CONV_MAX_NS + 8000));
        err_count++;
        $display("ERROR watchdog expected done seen timeout");
        finish_test();
    end
endmodule

`default_nettype wire
